//--- src/pwm_top.sv
// pwm_top: four-channel pulse-width modulator with prescaled clock sources
// assumes control ports are driven from the same clock; pins come from outside
//
// Summary of operation
// - four 8-bit channels, joinable into 16-bit pairs
// - each channel owns period, duty and counter
// - four clock sources, chosen per channel
// - duty ranges fully off to fully on
// - left or center alignment per channel
// - enabled channel applies new values at rollover
// - disabled channel writes take effect immediately
// - counter write resets count, latches buffers
// - counter value readable by software
// - enabled channel overrides the port pin
// - unused pin stays general purpose port
// - joined pair: low channel high byte, drives
// - seven-bit prescaler divides by one to 128
// - scaled clock is base/(scale+1)/2
// - left aligned polarity selects starting level
`timescale 1ns/1ps
module pwm_top (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic JOIN_PAIR_LOW,
  input wire logic JOIN_PAIR_HIGH,
  input wire logic [2:0] BASE_CLOCK_A_DIVIDER,
  input wire logic [2:0] BASE_CLOCK_B_DIVIDER,
  input wire logic [7:0] SCALED_CLOCK_ZERO_DIVISOR,
  input wire logic [7:0] SCALED_CLOCK_ONE_DIVISOR,
  input wire logic WR_SCALE_ZERO,
  input wire logic WR_SCALE_ONE,
  input wire logic [3:0] CHANNEL_CLOCK_CHOICE,
  input wire logic [3:0] CHANNEL_POLARITY,
  input wire logic [3:0] CHANNEL_CENTER,
  input wire logic [3:0] CHANNEL_OUTPUT_ENABLE,
  input wire logic [3:0] WR_PERIOD,
  input wire logic [3:0] WR_DUTY,
  input wire logic [3:0] WR_COUNT,
  input wire logic [7:0] WR_DATA,
  input wire logic [1:0] READ_SEL,
  output logic [7:0] COUNT_READ,
  input wire logic [3:0] PORT_DATA,
  input wire logic [3:0] PORT_DIR,
  input wire logic [3:0] PIN_IN,
  output logic [3:0] PIN_OUT,
  output logic [3:0] PIN_OE,
  output logic [3:0] PORT_IN_READ
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_s1_r, rst_n;
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  logic [3:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end else if (CE) begin
      pin_s1_r <= PIN_IN;
      pin_s2_r <= pin_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler runs only while some channel is on, to save power
  logic [6:0] pre_r, pre_nxt;
  logic any_en, tick_a, tick_b;
  logic [7:0] sc0_r, sc0_nxt, sc1_r, sc1_nxt;
  logic s0_r, s0_nxt, s1_r, s1_nxt, tick_s0, tick_s1;

  function automatic logic pre_tick(input logic [6:0] cnt, input logic [2:0] code);
    logic [6:0] mask;
    mask = 7'((8'h01 << code) - 8'h01);
    pre_tick = (cnt & mask) == mask;
  endfunction : pre_tick

  always_comb begin
    any_en = |CHANNEL_OUTPUT_ENABLE;
    pre_nxt = any_en ? pre_r + 7'h01 : pwm_pkg::PRESCALE_RESET;
    tick_a = any_en && pre_tick(pre_r, BASE_CLOCK_A_DIVIDER);
    tick_b = any_en && pre_tick(pre_r, BASE_CLOCK_B_DIVIDER);
    // down counter reloads at zero; each reload flips the half-rate output
    sc0_nxt = sc0_r;
    s0_nxt = s0_r;
    tick_s0 = 1'b0;
    if (WR_SCALE_ZERO) begin
      sc0_nxt = SCALED_CLOCK_ZERO_DIVISOR;
    end else if (tick_a) begin
      if (sc0_r == 8'h00) begin
        sc0_nxt = SCALED_CLOCK_ZERO_DIVISOR;
        s0_nxt = ~s0_r;
        tick_s0 = s0_r;
      end else begin
        sc0_nxt = sc0_r - 8'h01;
      end
    end
    sc1_nxt = sc1_r;
    s1_nxt = s1_r;
    tick_s1 = 1'b0;
    if (WR_SCALE_ONE) begin
      sc1_nxt = SCALED_CLOCK_ONE_DIVISOR;
    end else if (tick_b) begin
      if (sc1_r == 8'h00) begin
        sc1_nxt = SCALED_CLOCK_ONE_DIVISOR;
        s1_nxt = ~s1_r;
        tick_s1 = s1_r;
      end else begin
        sc1_nxt = sc1_r - 8'h01;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= pwm_pkg::PRESCALE_RESET;
      sc0_r <= pwm_pkg::SCALE_RESET;
      sc1_r <= pwm_pkg::SCALE_RESET;
      s0_r <= 1'b0;
      s1_r <= 1'b0;
    end else if (CE) begin
      pre_r <= pre_nxt;
      sc0_r <= sc0_nxt;
      sc1_r <= sc1_nxt;
      s0_r <= s0_nxt;
      s1_r <= s1_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per channel tick: 0,1 from A or S0; 2,3 from B or S1
  logic [3:0] ch_tick;
  always_comb begin
    ch_tick[0] = CHANNEL_CLOCK_CHOICE[0] ? tick_s0 : tick_a;
    ch_tick[1] = CHANNEL_CLOCK_CHOICE[1] ? tick_s0 : tick_a;
    ch_tick[2] = CHANNEL_CLOCK_CHOICE[2] ? tick_s1 : tick_b;
    ch_tick[3] = CHANNEL_CLOCK_CHOICE[3] ? tick_s1 : tick_b;
  end

  // each pair is a 16-bit engine plus an 8-bit one; separate mode uses the low half of the first
  logic [1:0] join_pair;
  logic [3:0] wave;
  logic [15:0] pair_cnt [2];
  logic [7:0] lone_cnt [2];
  assign join_pair = {JOIN_PAIR_HIGH, JOIN_PAIR_LOW};

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pair
      localparam int LO = 2 * gp;
      localparam int HI = 2 * gp + 1;
      logic jn, en_main, wp, wd, wc;
      logic [15:0] pd, dd, cnt16;
      logic [15:0] per_hold_r, per_hold_nxt, duty_hold_r, duty_hold_nxt;
      // joined: lower channel is high byte and pin, upper sets clock
      assign jn = join_pair[gp];
      // a joined pair is enabled through its lower channel only
      assign en_main = CHANNEL_OUTPUT_ENABLE[LO];
      // high byte waits here until the low byte write loads the full word
      always_comb begin
        per_hold_nxt = per_hold_r;
        duty_hold_nxt = duty_hold_r;
        if (WR_PERIOD[LO]) per_hold_nxt[15:8] = WR_DATA;
        if (WR_PERIOD[HI]) per_hold_nxt[7:0] = WR_DATA;
        if (WR_DUTY[LO]) duty_hold_nxt[15:8] = WR_DATA;
        if (WR_DUTY[HI]) duty_hold_nxt[7:0] = WR_DATA;
      end
      always_ff @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
          per_hold_r <= 16'h0000;
          duty_hold_r <= 16'h0000;
        end else if (CE) begin
          per_hold_r <= per_hold_nxt;
          duty_hold_r <= duty_hold_nxt;
        end
      end
      assign wp = jn ? WR_PERIOD[HI] : WR_PERIOD[LO];
      assign wd = jn ? WR_DUTY[HI] : WR_DUTY[LO];
      assign wc = jn ? (WR_COUNT[LO] | WR_COUNT[HI]) : WR_COUNT[LO];
      assign pd = jn ? {per_hold_r[15:8], WR_DATA} : {8'h00, WR_DATA};
      assign dd = jn ? {duty_hold_r[15:8], WR_DATA} : {8'h00, WR_DATA};
      pwm_channel #(.W(16)) u_main (
        .clk(CLOCK),
        .rst_n(rst_n),
        .ce(CE),
        .tick(jn ? ch_tick[HI] : ch_tick[LO]),
        .enable(en_main),
        .center(CHANNEL_CENTER[LO]),
        .polarity(CHANNEL_POLARITY[LO]),
        .wr_period(wp),
        .wr_duty(wd),
        .wr_count(wc),
        .period_in(pd),
        .duty_in(dd),
        .count_r(cnt16),
        .wave_r(wave[LO])
      );
      pwm_channel #(.W(8)) u_aux (
        .clk(CLOCK),
        .rst_n(rst_n),
        .ce(CE),
        .tick(ch_tick[HI]),
        .enable(CHANNEL_OUTPUT_ENABLE[HI] && !jn),
        .center(CHANNEL_CENTER[HI]),
        .polarity(CHANNEL_POLARITY[HI]),
        .wr_period(WR_PERIOD[HI] && !jn),
        .wr_duty(WR_DUTY[HI] && !jn),
        .wr_count(WR_COUNT[HI] && !jn),
        .period_in(WR_DATA),
        .duty_in(WR_DATA),
        .count_r(lone_cnt[gp]),
        .wave_r(wave[HI])
      );
      assign pair_cnt[gp] = cnt16;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] pwm_own;
  logic [3:0] pin_out_nxt, pin_oe_nxt;
  logic [7:0] cnt_nxt;
  always_comb begin
    pwm_own[0] = CHANNEL_OUTPUT_ENABLE[0];
    pwm_own[1] = CHANNEL_OUTPUT_ENABLE[1] && !JOIN_PAIR_LOW;
    pwm_own[2] = CHANNEL_OUTPUT_ENABLE[2];
    pwm_own[3] = CHANNEL_OUTPUT_ENABLE[3] && !JOIN_PAIR_HIGH;
    // waveform takes the pin; otherwise the port owns it
    pin_out_nxt = (pwm_own & wave) | (~pwm_own & PORT_DATA);
    pin_oe_nxt = pwm_own | PORT_DIR;
    // count readback per channel; joined pair splits into bytes
    case (READ_SEL)
      2'h0: cnt_nxt = JOIN_PAIR_LOW ? pair_cnt[0][15:8] : pair_cnt[0][7:0];
      2'h1: cnt_nxt = JOIN_PAIR_LOW ? pair_cnt[0][7:0] : lone_cnt[0];
      2'h2: cnt_nxt = JOIN_PAIR_HIGH ? pair_cnt[1][15:8] : pair_cnt[1][7:0];
      2'h3: cnt_nxt = JOIN_PAIR_HIGH ? pair_cnt[1][7:0] : lone_cnt[1];
      default: cnt_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      PIN_OUT <= 4'h0;
      PIN_OE <= 4'h0;
      COUNT_READ <= pwm_pkg::COUNT_RESET;
      PORT_IN_READ <= 4'h0;
    end else if (CE) begin
      PIN_OUT <= pin_out_nxt;
      PIN_OE <= pin_oe_nxt;
      COUNT_READ <= cnt_nxt;
      PORT_IN_READ <= pin_s2_r;
    end
  end

  property p_pin_owned;
    @(posedge CLOCK) disable iff (!rst_n) (CE && pwm_own[0]) |=> PIN_OE[0];
  endproperty
  a_pin_owned: assert property (p_pin_owned) else $error("enabled pin not driven");

  property p_pin_port;
    @(posedge CLOCK) disable iff (!rst_n)
      (CE && !pwm_own[1]) |=> (PIN_OUT[1] == $past(PORT_DATA[1]));
  endproperty
  a_pin_port: assert property (p_pin_port) else $error("port pin not passed");

  property p_idle_prescaler;
    @(posedge CLOCK) disable iff (!rst_n) (CE && !any_en) |=> (pre_r == 7'h00);
  endproperty
  a_idle_prescaler: assert property (p_idle_prescaler) else $error("prescaler ran idle");

  property p_scale_reload;
    @(posedge CLOCK) disable iff (!rst_n)
      (CE && WR_SCALE_ZERO) |=> (sc0_r == $past(SCALED_CLOCK_ZERO_DIVISOR));
  endproperty
  a_scale_reload: assert property (p_scale_reload) else $error("scale not loaded");

  property p_scale_one_load;
    @(posedge CLOCK) disable iff (!rst_n)
      (CE && WR_SCALE_ONE) |=> (sc1_r == $past(SCALED_CLOCK_ONE_DIVISOR));
  endproperty
  a_scale_one_load: assert property (p_scale_one_load) else $error("scale one lost");

  property p_joined_pin_free;
    @(posedge CLOCK) disable iff (!rst_n)
      (CE && JOIN_PAIR_LOW) |=> (PIN_OE[1] == $past(PORT_DIR[1]));
  endproperty
  a_joined_pin_free: assert property (p_joined_pin_free) else $error("joined pin held");

  property p_slowest_base;
    @(posedge CLOCK) disable iff (!rst_n)
      (tick_a && BASE_CLOCK_A_DIVIDER == 3'h7) |-> (pre_r == 7'h7F);
  endproperty
  a_slowest_base: assert property (p_slowest_base) else $error("base tick off phase");

  c_joined_low: cover property (@(posedge CLOCK) disable iff (!rst_n) JOIN_PAIR_LOW && pwm_own[0]);
  c_s0_tick: cover property (@(posedge CLOCK) disable iff (!rst_n) tick_s0);
  c_center: cover property (@(posedge CLOCK) disable iff (!rst_n) CHANNEL_CENTER[2] && PIN_OE[2]);
endmodule : pwm_top

//--- src/pwm_pkg.sv
// pwm_pkg: constants shared by the four-channel pulse-width modulator
// assumes a single 10 MHz clock domain and plain control ports
package pwm_pkg;
  localparam int CHANNELS = 4;
  localparam int CH_WIDTH = 8;
  localparam int PRESCALE_BITS = 7;
  localparam int PRESCALE_CODE_BITS = 3;
  localparam int SCALE_BITS = 8;
  localparam logic [7:0] PERIOD_RESET = 8'h00;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] SCALE_RESET = 8'h00;
  localparam logic [6:0] PRESCALE_RESET = 7'h00;
  localparam int CLOCK_HZ = 10000000;
  localparam int SYNC_STAGES = 2;
endpackage : pwm_pkg

//--- src/pwm_channel.sv
// pwm_channel: one 8-bit slice or a joined 16-bit pair, with buffered period and duty
// assumes tick is a one-cycle pulse from the selected clock source
`timescale 1ns/1ps
module pwm_channel #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic enable,
  input wire logic center,
  input wire logic polarity,
  input wire logic wr_period,
  input wire logic wr_duty,
  input wire logic wr_count,
  input wire logic [W-1:0] period_in,
  input wire logic [W-1:0] duty_in,
  output logic [W-1:0] count_r,
  output logic wave_r
);
  logic [W-1:0] per_buf_r, per_buf_nxt, duty_buf_r, duty_buf_nxt;
  logic [W-1:0] per_act_r, per_act_nxt, duty_act_r, duty_act_nxt, count_nxt;
  logic down_r, down_nxt, wave_nxt, roll;

  always_comb begin
    per_buf_nxt = wr_period ? period_in : per_buf_r;
    duty_buf_nxt = wr_duty ? duty_in : duty_buf_r;
    per_act_nxt = per_act_r;
    duty_act_nxt = duty_act_r;
    count_nxt = count_r;
    down_nxt = down_r;
    wave_nxt = wave_r;
    roll = 1'b0;
    if (!enable) begin
      // disabled: writes go straight through, so no mixed waveform
      per_act_nxt = per_buf_nxt;
      duty_act_nxt = duty_buf_nxt;
      count_nxt = '0;
      down_nxt = 1'b0;
    end else if (wr_count) begin
      // counter write forces new values at once
      per_act_nxt = per_buf_nxt;
      duty_act_nxt = duty_buf_nxt;
      count_nxt = '0;
      down_nxt = 1'b0;
    end else if (tick) begin
      if (!center) begin
        roll = (count_r + W'(1)) >= per_act_r;
        count_nxt = roll ? '0 : count_r + W'(1);
      end else begin
        // count up to period then back down
        if (!down_r) begin
          if (count_r + W'(1) >= per_act_r) down_nxt = 1'b1;
          count_nxt = (count_r >= per_act_r) ? count_r : count_r + W'(1);
        end else begin
          roll = (count_r <= W'(1));
          if (roll) down_nxt = 1'b0;
          count_nxt = (count_r == '0) ? '0 : count_r - W'(1);
        end
      end
      if (roll) begin
        // buffered values applied only at rollover
        per_act_nxt = per_buf_r;
        duty_act_nxt = duty_buf_r;
      end
    end
    // level from compare: duty 0 and duty >= period (center: duty > period) give the two extremes
    if (!center) begin
      // left aligned: polarity 0 low then high at duty
      wave_nxt = (count_nxt < duty_act_nxt) ? polarity : ~polarity;
    end else begin
      wave_nxt = (count_nxt < duty_act_nxt) ? ~polarity : polarity;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_buf_r <= '0;
      duty_buf_r <= '0;
      per_act_r <= '0;
      duty_act_r <= '0;
      count_r <= '0;
      down_r <= 1'b0;
      wave_r <= 1'b0;
    end else if (ce) begin
      per_buf_r <= per_buf_nxt;
      duty_buf_r <= duty_buf_nxt;
      per_act_r <= per_act_nxt;
      duty_act_r <= duty_act_nxt;
      count_r <= count_nxt;
      down_r <= down_nxt;
      wave_r <= wave_nxt;
    end
  end

  property p_count_write_clears;
    @(posedge clk) disable iff (!rst_n) (ce && enable && wr_count) |=> (count_r == '0);
  endproperty
  a_count_write_clears: assert property (p_count_write_clears) else $error("count not cleared");

  property p_disabled_idle;
    @(posedge clk) disable iff (!rst_n) (ce && !enable) |=> (count_r == '0);
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("count moved while off");

  property p_left_bound;
    @(posedge clk) disable iff (!rst_n)
      (enable && !center && per_act_r != '0) |-> (count_r < per_act_r);
  endproperty
  a_left_bound: assert property (p_left_bound) else $error("count passed period");

  property p_duty_zero_flat;
    @(posedge clk) disable iff (!rst_n)
      (ce && duty_act_nxt == '0 && !center) |=> (wave_r == !$past(polarity));
  endproperty
  a_duty_zero_flat: assert property (p_duty_zero_flat) else $error("duty zero not flat");

  c_roll: cover property (@(posedge clk) disable iff (!rst_n) ce && roll);
  c_center_down: cover property (@(posedge clk) disable iff (!rst_n) down_r ##1 !down_r);
endmodule : pwm_channel

//--- test/pwm_pins_model.sv
// pwm_pins_model: external loads on the four shared port pins
// assumes pin_in feeds PIN_IN; ext_en marks an outside driver on a pin
`timescale 1ns/1ps
module pwm_pins_model (
  input wire logic clk,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  output logic [3:0] pin_in
);
  logic [3:0] float_r = 4'h0;
  // no pull on these pins, so a floating pin toggles instead of holding a level
  always @(posedge clk) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pin_oe[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else begin
        pin_in[i] = float_r[i];
      end
    end
  end
endmodule : pwm_pins_model

//--- test/pwm_top_test.sv
// pwm_top_test: self-checking bench for the four-channel modulator
// assumes one 10 MHz clock; inputs change by nba at the rising edge
`timescale 1ns/1ps
module pwm_top_test;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  logic jl = 1'b0;
  logic ws1 = 1'b0;
  logic [2:0] da = 3'h0, db = 3'h0;
  logic [7:0] s1 = 8'h00, wd = 8'h00, cr;
  logic [3:0] cc = 4'h0, pol = 4'h0, cen = 4'h0, en = 4'h0, wp = 4'h0, wdu = 4'h0;
  logic [3:0] wc = 4'h0, pd = 4'h0, pdir = 4'h0, ee = 4'h0, ev = 4'h0;
  logic [3:0] pin_in, po, poe, pir;
  logic [1:0] rs = 2'h0;
  int bad_count = 0;
  int comparisons = 0;
  pwm_top uut (.CLOCK(CLOCK), .RESETN(RESETN), .CE(1'b1), .JOIN_PAIR_LOW(jl),
    .JOIN_PAIR_HIGH(1'b0), .BASE_CLOCK_A_DIVIDER(da), .BASE_CLOCK_B_DIVIDER(db),
    .SCALED_CLOCK_ZERO_DIVISOR(s1), .SCALED_CLOCK_ONE_DIVISOR(s1),
    .WR_SCALE_ZERO(ws1), .WR_SCALE_ONE(ws1), .CHANNEL_CLOCK_CHOICE(cc),
    .CHANNEL_POLARITY(pol), .CHANNEL_CENTER(cen), .CHANNEL_OUTPUT_ENABLE(en),
    .WR_PERIOD(wp), .WR_DUTY(wdu), .WR_COUNT(wc), .WR_DATA(wd), .READ_SEL(rs),
    .COUNT_READ(cr), .PORT_DATA(pd), .PORT_DIR(pdir), .PIN_IN(pin_in),
    .PIN_OUT(po), .PIN_OE(poe), .PORT_IN_READ(pir));
  pwm_pins_model loads (.clk(CLOCK), .pin_out(po), .pin_oe(poe), .ext_en(ee),
    .ext_val(ev), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // prescaler phase is unknown, so counts get a small tolerance
  task automatic near(input string what, input logic [15:0] got, input int exp);
    check(what, 16'(got + 2 >= exp && got <= exp + 2), 16'h0001);
  endtask : near
  task automatic wr(input logic [2:0] k, input int ch, input logic [7:0] d);
    @(posedge CLOCK);
    wp[ch] <= k[0];
    wdu[ch] <= k[1];
    wc[ch] <= k[2];
    wd <= d;
    @(posedge CLOCK);
    wp <= 4'h0;
    wdu <= 4'h0;
    wc <= 4'h0;
  endtask : wr
  task automatic prog(input int ch, input logic [7:0] p, input logic [7:0] d);
    en[ch] <= 1'b0;
    wr(3'h1, ch, p);
    wr(3'h2, ch, d);
    en[ch] <= 1'b1;
    repeat (4) @(posedge CLOCK);
  endtask : prog
  task automatic meas(input int ch, input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge CLOCK);
      #1 h += int'(po[ch] === 1'b1);
    end
  endtask : meas
  task automatic rate(input int ch, output logic [15:0] n);
    rs <= 2'(ch);
    wr(3'h4, ch, 8'h00);
    repeat (128) @(posedge CLOCK);
    #1 n = {8'h00, cr};
  endtask : rate
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_left();
    int dt[5] = '{3, 3, 0, 10, 10};
    int ht[5] = '{28, 12, 40, 40, 0};
    int h;
    for (int ch = 0; ch < 4; ch += 3) begin
      for (int i = 0; i < 5; i++) begin
        pol[ch] <= i[0];
        prog(ch, 8'h0A, 8'(dt[i]));
        meas(ch, 40, h);
        check("left high count", 16'(h), 16'(ht[i]));
      end
    end
    $display("left aligned done");
  endtask : t_left
  task automatic t_buf();
    int h;
    rs <= 2'h1;
    prog(1, 8'h64, 8'h32);
    wr(3'h4, 1, 8'h00);
    @(posedge CLOCK);
    #1 check("count after write", {8'h00, cr}, 16'h0000);
    wr(3'h2, 1, 8'h0A);
    meas(1, 40, h);
    check("old duty held", 16'(h), 16'h0000);
    repeat (60) @(posedge CLOCK);
    meas(1, 100, h);
    check("new duty at rollover", 16'(h), 16'h005A);
    $display("buffering done");
  endtask : t_buf
  task automatic t_center();
    int h;
    cen[2] <= 1'b1;
    prog(2, 8'h0A, 8'h03);
    meas(2, 200, h);
    check("center high count", 16'(h >= 50 && h <= 60), 16'h0001);
    cen[2] <= 1'b0;
    $display("center aligned done");
  endtask : t_center
  task automatic t_rate();
    int vt[3] = '{0, 1, 3};
    logic [15:0] n;
    for (int c = 0; c < 8; c++) begin
      da <= 3'(c);
      prog(0, 8'hFF, 8'h80);
      rate(0, n);
      near("base clock rate", n, 128 >> c);
    end
    cc[2] <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      s1 <= 8'(vt[i]);
      ws1 <= 1'b1;
      @(posedge CLOCK);
      ws1 <= 1'b0;
      prog(2, 8'hFF, 8'h80);
      rate(2, n);
      near("scaled clock rate", n, 128 / (2 * (vt[i] + 1)));
    end
    cc[2] <= 1'b0;
    $display("clock sources done");
  endtask : t_rate
  task automatic t_join();
    int h;
    jl <= 1'b1;
    da <= 3'h0;
    en <= 4'h0;
    pol[0] <= 1'b0;
    pdir[1] <= 1'b1;
    pd[1] <= 1'b1;
    wr(3'h1, 0, 8'h01);
    wr(3'h1, 1, 8'h00);
    wr(3'h2, 0, 8'h00);
    wr(3'h2, 1, 8'h40);
    en[0] <= 1'b1;
    repeat (4) @(posedge CLOCK);
    meas(0, 512, h);
    check("joined high count", 16'(h), 16'h0180);
    check("freed pin", {14'h0, poe[1], po[1]}, 16'h0003);
    jl <= 1'b0;
    en <= 4'h0;
    $display("joined pair done");
  endtask : t_join
  task automatic t_port();
    pdir[3] <= 1'b1;
    pd[3] <= 1'b1;
    repeat (3) @(posedge CLOCK);
    #1 check("port drive", {14'h0, poe[3], po[3]}, 16'h0003);
    pdir[3] <= 1'b0;
    ee[3] <= 1'b1;
    ev[3] <= 1'b1;
    repeat (5) @(posedge CLOCK);
    #1 check("port released", {15'h0, poe[3]}, 16'h0000);
    check("port input high", {15'h0, pir[3]}, 16'h0001);
    ev[3] <= 1'b0;
    repeat (5) @(posedge CLOCK);
    #1 check("port input low", {15'h0, pir[3]}, 16'h0000);
    ee[3] <= 1'b0;
    prog(3, 8'h0A, 8'h05);
    #1 check("channel owns pin", {15'h0, poe[3]}, 16'h0001);
    $display("port sharing done");
  endtask : t_port
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    forever #50 CLOCK = ~CLOCK;
  end
  // all tests together take a few thousand cycles
  initial begin
    repeat (20000) @(posedge CLOCK);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge CLOCK);
    check("pins in reset", {8'h00, poe, po}, 16'h0000);
    check("count in reset", {8'h00, cr}, 16'h0000);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLOCK);
    t_left();
    t_buf();
    t_center();
    t_rate();
    t_join();
    t_port();
    conclude();
  end
endmodule : pwm_top_test
